// file: src/nvc_nvm_access.sv
// Purpose: Register-level access to program flash, data EEPROM and configuration space.
// Assumes: This block holds memReq until the array pulses memAck on the same clock.
// Notes: Data registers power up at zero here; software must not rely on any value.
//
// What this block does
// - Config select routes accesses to configuration region.
// - Config region has top address bit set.
// - Refused config read clears both data registers.
// - User IDs read/write; device ID read only.
// - Configuration words readable, never writable here.
// - Low data register: eight bits, read/write.
// - High data: six bits, top two read zero.
// - Address low: eight bits, resets to zero.
// - Address high: seven bits, top reads one.
`timescale 1ns/1ns
module nvc_nvm_access
  import nvc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NVC_AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [NVC_AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output nvc_mem_req_t memReq,
  input wire logic memAck,
  input wire logic [13:0] memRdData
);

  logic regWe;
  logic [NVC_AXI_AW-1:0] regWaddr;
  logic [7:0] regWdata;
  logic [31:0] rdData;
  logic cfgReadOk, cfgWriteOk;

  nvc_state_t state_r, state_nxt;
  nvc_mem_req_t memReq_r, memReq_nxt;
  logic [7:0] dataLo_r, dataLo_nxt;
  logic [5:0] dataHi_r, dataHi_nxt;
  logic [7:0] addrLo_r, addrLo_nxt;
  logic [6:0] addrHi_r, addrHi_nxt;
  logic pgmSel_r, pgmSel_nxt;
  logic cfgSel_r, cfgSel_nxt;
  logic wrEn_r, wrEn_nxt;
  logic wrBusy_r, wrBusy_nxt;
  logic rdBusy_r, rdBusy_nxt;

  nvc_axil_slave u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .regWe(regWe),
    .regWaddr(regWaddr),
    .regWdata(regWdata),
    .rdData(rdData)
  );

  // The configuration window sits where the top program-counter bit is set.
  nvc_cfg_guard u_guard (
    .cfgAddr({NVC_CFG_MSB, addrHi_r, addrLo_r}),
    .readOk(cfgReadOk),
    .writeOk(cfgWriteOk)
  );

  // Register read mux; unimplemented bits read as documented, unmapped as zero.
  always_comb begin
    rdData = NVC_RST_WORD;
    unique case (s_axil_araddr)
      NVC_OFF_DATA_LO: rdData[7:0] = dataLo_r;
      NVC_OFF_DATA_HI: rdData[7:0] = {NVC_DATA_HI_TOP, dataHi_r};
      NVC_OFF_ADDR_LO: rdData[7:0] = addrLo_r;
      NVC_OFF_ADDR_HI: rdData[7:0] = {NVC_ADDR_HI_TOP, addrHi_r};
      NVC_OFF_CTRL: begin
        rdData[NVC_CTL_PGM] = pgmSel_r;
        rdData[NVC_CTL_CFG] = cfgSel_r;
        rdData[NVC_CTL_WREN] = wrEn_r;
        rdData[NVC_CTL_WR] = wrBusy_r;
        rdData[NVC_CTL_RD] = rdBusy_r;
      end
      default: rdData = NVC_RST_WORD;
    endcase
  end

  // Software writes first, then the access sequencer; hardware updates of
  // the same register win because the array result must not be lost.
  always_comb begin
    state_nxt = state_r;
    memReq_nxt = memReq_r;
    dataLo_nxt = dataLo_r;
    dataHi_nxt = dataHi_r;
    addrLo_nxt = addrLo_r;
    addrHi_nxt = addrHi_r;
    pgmSel_nxt = pgmSel_r;
    cfgSel_nxt = cfgSel_r;
    wrEn_nxt = wrEn_r;
    wrBusy_nxt = wrBusy_r;
    rdBusy_nxt = rdBusy_r;
    if (regWe) begin
      unique case (regWaddr)
        NVC_OFF_DATA_LO: dataLo_nxt = regWdata;
        NVC_OFF_DATA_HI: dataHi_nxt = regWdata[5:0];
        NVC_OFF_ADDR_LO: addrLo_nxt = regWdata;
        NVC_OFF_ADDR_HI: addrHi_nxt = regWdata[6:0];
        NVC_OFF_CTRL: begin
          pgmSel_nxt = regWdata[NVC_CTL_PGM];
          cfgSel_nxt = regWdata[NVC_CTL_CFG];
          wrEn_nxt = regWdata[NVC_CTL_WREN];
          // Start bits can only be set by software; hardware clears them.
          wrBusy_nxt = wrBusy_r | regWdata[NVC_CTL_WR];
          rdBusy_nxt = rdBusy_r | regWdata[NVC_CTL_RD];
        end
        default: begin
        end
      endcase
    end
    unique case (state_r)
      NVC_IDLE: begin
        if (rdBusy_r) begin
          if (cfgSel_r && !cfgReadOk) begin
            // A refused read returns zero rather than array contents.
            dataLo_nxt = NVC_RST_BYTE;
            dataHi_nxt = '0;
            rdBusy_nxt = 1'b0;
          end else begin
            memReq_nxt.rd = 1'b1;
            memReq_nxt.cfg = cfgSel_r;
            memReq_nxt.pgm = pgmSel_r;
            memReq_nxt.addr = {addrHi_r, addrLo_r};
            state_nxt = NVC_READ;
          end
        end else if (wrBusy_r) begin
          if (!wrEn_r || (cfgSel_r && !cfgWriteOk)) begin
            // Drop the write without touching the array.
            wrBusy_nxt = 1'b0;
          end else begin
            memReq_nxt.wr = 1'b1;
            memReq_nxt.cfg = cfgSel_r;
            memReq_nxt.pgm = pgmSel_r;
            memReq_nxt.addr = {addrHi_r, addrLo_r};
            memReq_nxt.data = {dataHi_r, dataLo_r};
            state_nxt = NVC_WRITE;
          end
        end
      end
      NVC_READ: begin
        if (memAck) begin
          dataLo_nxt = memRdData[7:0];
          dataHi_nxt = memRdData[13:8];
          memReq_nxt.rd = 1'b0;
          rdBusy_nxt = 1'b0;
          state_nxt = NVC_IDLE;
        end
      end
      NVC_WRITE: begin
        if (memAck) begin
          memReq_nxt.wr = 1'b0;
          wrBusy_nxt = 1'b0;
          state_nxt = NVC_IDLE;
        end
      end
      default: begin
        state_nxt = NVC_IDLE;
        memReq_nxt.rd = 1'b0;
        memReq_nxt.wr = 1'b0;
      end
    endcase
  end

  // All control state resets; the data pair resets too, which is one legal
  // value of an otherwise unknown power-on content.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= NVC_IDLE;
      memReq_r <= '0;
      dataLo_r <= NVC_RST_BYTE;
      dataHi_r <= '0;
      addrLo_r <= NVC_RST_BYTE;
      addrHi_r <= '0;
      pgmSel_r <= 1'b0;
      cfgSel_r <= 1'b0;
      wrEn_r <= 1'b0;
      wrBusy_r <= 1'b0;
      rdBusy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      memReq_r <= memReq_nxt;
      dataLo_r <= dataLo_nxt;
      dataHi_r <= dataHi_nxt;
      addrLo_r <= addrLo_nxt;
      addrHi_r <= addrHi_nxt;
      pgmSel_r <= pgmSel_nxt;
      cfgSel_r <= cfgSel_nxt;
      wrEn_r <= wrEn_nxt;
      wrBusy_r <= wrBusy_nxt;
      rdBusy_r <= rdBusy_nxt;
    end
  end

  assign memReq = memReq_r;

endmodule : nvc_nvm_access

// file: include/nvc_pkg.sv
// Purpose: Shared constants, types and decode for the NVM access block.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word.
// Notes: Byte offsets below are the bus byte addresses.
package nvc_pkg;

  localparam int NVC_AXI_AW = 8;

  // Register byte offsets.
  localparam logic [7:0] NVC_OFF_DATA_LO = 8'h00;
  localparam logic [7:0] NVC_OFF_DATA_HI = 8'h04;
  localparam logic [7:0] NVC_OFF_ADDR_LO = 8'h08;
  localparam logic [7:0] NVC_OFF_ADDR_HI = 8'h0C;
  localparam logic [7:0] NVC_OFF_CTRL = 8'h10;

  // Control register bit positions.
  localparam int NVC_CTL_PGM = 7;
  localparam int NVC_CTL_CFG = 6;
  localparam int NVC_CTL_WREN = 2;
  localparam int NVC_CTL_WR = 1;
  localparam int NVC_CTL_RD = 0;

  // Values after reset and fixed read-back bits.
  localparam logic [7:0] NVC_RST_BYTE = 8'h00;
  localparam logic NVC_ADDR_HI_TOP = 1'b1;
  localparam logic [1:0] NVC_DATA_HI_TOP = 2'b00;
  localparam logic [31:0] NVC_RST_WORD = 32'h0000_0000;

  // Configuration region: top address bit set, then the permitted words.
  localparam logic NVC_CFG_MSB = 1'b1;
  localparam logic [15:0] NVC_UID_FIRST = 16'h8000;
  localparam logic [15:0] NVC_UID_LAST = 16'h8003;
  localparam logic [15:0] NVC_DEVID = 16'h8006;
  localparam logic [15:0] NVC_CFGW_FIRST = 16'h8007;
  localparam logic [15:0] NVC_CFGW_LAST = 16'h8008;

  // AXI responses.
  localparam logic [1:0] NVC_RESP_OKAY = 2'b00;
  localparam logic [1:0] NVC_RESP_SLVERR = 2'b10;

  // Request held toward the flash/EEPROM array until it acknowledges.
  typedef struct packed {
    logic rd;
    logic wr;
    logic cfg;
    logic pgm;
    logic [14:0] addr;
    logic [13:0] data;
  } nvc_mem_req_t;

  typedef enum logic [2:0] {
    NVC_IDLE = 3'b001,
    NVC_READ = 3'b010,
    NVC_WRITE = 3'b100
  } nvc_state_t;

  // True when a bus byte address hits one of the five registers.
  function automatic logic nvc_mapped(input logic [NVC_AXI_AW-1:0] a);
    return (a == NVC_OFF_DATA_LO) || (a == NVC_OFF_DATA_HI) || (a == NVC_OFF_ADDR_LO) ||
           (a == NVC_OFF_ADDR_HI) || (a == NVC_OFF_CTRL);
  endfunction : nvc_mapped

endpackage : nvc_pkg

// file: src/nvc_cfg_guard.sv
// Purpose: Read and write permission decode for configuration space.
// Assumes: Address already carries the top bit of the region.
// Notes: Purely combinational; any address not listed is refused both ways.
`timescale 1ns/1ns
module nvc_cfg_guard
  import nvc_pkg::*;
(
  input wire logic [15:0] cfgAddr,
  output logic readOk,
  output logic writeOk
);

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : inRange

  // User IDs are read/write; device ID and configuration words are read only.
  always_comb begin
    writeOk = inRange(cfgAddr, NVC_UID_FIRST, NVC_UID_LAST);
    readOk = writeOk || (cfgAddr == NVC_DEVID) ||
             inRange(cfgAddr, NVC_CFGW_FIRST, NVC_CFGW_LAST);
  end

endmodule : nvc_cfg_guard

// file: src/nvc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the NVM access registers.
// Assumes: One write and one read outstanding at most.
// Notes: Address and data are taken in either order; unmapped answers SLVERR.
`timescale 1ns/1ns
module nvc_axil_slave
  import nvc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NVC_AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [NVC_AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic regWe,
  output logic [NVC_AXI_AW-1:0] regWaddr,
  output logic [7:0] regWdata,
  input wire logic [31:0] rdData
);

  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [NVC_AXI_AW-1:0] awAddr_r, awAddr_nxt;
  logic [7:0] wData_r, wData_nxt;
  logic wLane_r, wLane_nxt;
  logic awReady_r, awReady_nxt, wReady_r, wReady_nxt, bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic arReady_r, arReady_nxt, rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic doWrite;

  // Commit the write once both halves are held and no response is pending.
  // A cleared byte lane 0 leaves the register alone but still answers OKAY.
  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wLane_nxt = wLane_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    if (s_axil_awvalid && awReady_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axil_awaddr;
    end
    if (s_axil_wvalid && wReady_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axil_wdata[7:0];
      wLane_nxt = s_axil_wstrb[0];
    end
    doWrite = awHeld_r && wHeld_r && !bValid_r;
    if (bValid_r && s_axil_bready) begin
      bValid_nxt = 1'b0;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = nvc_mapped(awAddr_r) ? NVC_RESP_OKAY : NVC_RESP_SLVERR;
    end
    awReady_nxt = !awHeld_nxt;
    wReady_nxt = !wHeld_nxt;
    regWe = doWrite && wLane_r;
    regWaddr = awAddr_r;
    regWdata = wData_r;
  end

  // Read data is captured at the address handshake, so rvalid follows one edge later.
  always_comb begin
    arReady_nxt = arReady_r;
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axil_arvalid && arReady_r) begin
      arReady_nxt = 1'b0;
      rValid_nxt = 1'b1;
      rData_nxt = rdData;
      rResp_nxt = nvc_mapped(s_axil_araddr) ? NVC_RESP_OKAY : NVC_RESP_SLVERR;
    end else if (rValid_r && s_axil_rready) begin
      rValid_nxt = 1'b0;
      arReady_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= NVC_RST_BYTE;
      wLane_r <= 1'b0;
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= NVC_RESP_OKAY;
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= NVC_RST_WORD;
      rResp_r <= NVC_RESP_OKAY;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wLane_r <= wLane_nxt;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      arReady_r <= (rValid_r || rValid_nxt) ? arReady_nxt : 1'b1;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  assign s_axil_awready = awReady_r;
  assign s_axil_wready = wReady_r;
  assign s_axil_bvalid = bValid_r;
  assign s_axil_bresp = bResp_r;
  assign s_axil_arready = arReady_r;
  assign s_axil_rvalid = rValid_r;
  assign s_axil_rdata = rData_r;
  assign s_axil_rresp = rResp_r;

endmodule : nvc_axil_slave

// file: bench/nvc_mem_model.sv
// Purpose: Behavioural flash/EEPROM array answering the block's held requests.
// Assumes: One request at a time, acknowledged by a one-cycle pulse.
// Notes: Read data toggles while idle so stale values are never trusted.
`timescale 1ns/1ns
module nvc_mem_model
  import nvc_pkg::*;
#(
  parameter logic [13:0] CfgSeed = 14'h1A00
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire nvc_mem_req_t memReq,
  input wire logic [3:0] ackDelay,
  output logic memAck,
  output logic [13:0] memRdData
);
  logic [13:0] mainMem [0:255];
  logic [13:0] cfgMem [0:15];
  logic [3:0] waitCnt;

  // Waits ackDelay cycles, then serves the request; CfgSeed contents are arbitrary.
  always_ff @(posedge ref_clk) begin
    memAck <= 1'b0;
    memRdData <= ~memRdData;
    if (rst) begin
      waitCnt <= 4'h0;
      memRdData <= 14'h0000;
      for (int i = 0; i < 16; i++) begin
        cfgMem[i] <= CfgSeed + 14'(i);
      end
    end else if ((memReq.rd || memReq.wr) && !memAck) begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt >= ackDelay) begin
        waitCnt <= 4'h0;
        memAck <= 1'b1;
        if (memReq.rd) begin
          memRdData <= memReq.cfg ? cfgMem[memReq.addr[3:0]] : mainMem[memReq.addr[7:0]];
        end else if (memReq.cfg) begin
          cfgMem[memReq.addr[3:0]] <= memReq.data;
        end else begin
          mainMem[memReq.addr[7:0]] <= memReq.data;
        end
      end
    end
  end
endmodule : nvc_mem_model

// file: bench/nvc_nvm_access_properties.sv
// Purpose: Port-level timing and value checks for the NVM access block.
// Assumes: One clock, synchronous active-high reset.
// Notes: The read address is remembered so each answer is judged per register.
`timescale 1ns/1ns
module nvc_nvm_access_properties
  import nvc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NVC_AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire nvc_mem_req_t memReq,
  input wire logic memAck
);
  logic [7:0] lastAr_r;
  logic okRd;

  // Captured at the handshake; only consulted while an answer stands.
  always_ff @(posedge ref_clk) begin
    if (s_axil_arvalid && s_axil_arready) begin
      lastAr_r <= s_axil_araddr;
    end
  end
  assign okRd = s_axil_rvalid && (s_axil_rresp == NVC_RESP_OKAY);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence arTake;
    s_axil_arvalid && s_axil_arready;
  endsequence
  sequence memBusy;
    (memReq.rd || memReq.wr) && !memAck;
  endsequence

  read_answer_a: assert property (arTake |=> s_axil_rvalid)
    else $error("read answer missing");
  low_bytes_a: assert property (okRd && (lastAr_r == NVC_OFF_DATA_LO ||
      lastAr_r == NVC_OFF_ADDR_LO) |-> s_axil_rdata[31:8] == 24'h00_0000)
    else $error("byte register upper bits set");
  data_high_a: assert property (okRd && lastAr_r == NVC_OFF_DATA_HI |->
      s_axil_rdata[31:6] == 26'h000_0000) else $error("data high top bits set");
  addr_high_a: assert property (okRd && lastAr_r == NVC_OFF_ADDR_HI |->
      s_axil_rdata[31:7] == 25'h000_0001) else $error("address high top bit wrong");
  unmapped_read_a: assert property (s_axil_rvalid && lastAr_r > NVC_OFF_CTRL |->
      s_axil_rresp == NVC_RESP_SLVERR && s_axil_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  r_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
      s_axil_rvalid && $stable(s_axil_rdata)) else $error("read answer dropped");
  b_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=>
      s_axil_bvalid && $stable(s_axil_bresp)) else $error("write answer dropped");
  cfg_read_a: assert property (memReq.rd && memReq.cfg |-> memReq.addr inside
      {[15'h0000:15'h0003], [15'h0006:15'h0008]}) else $error("refused read reached array");
  cfg_write_a: assert property (memReq.wr && memReq.cfg |->
      memReq.addr <= 15'h0003) else $error("refused write reached array");
  mem_hold_a: assert property (memBusy |=> $stable(memReq))
    else $error("array request changed before ack");
  mem_drop_a: assert property (memReq.rd && memAck |=> !memReq.rd && !memReq.wr)
    else $error("array request kept after ack");
endmodule : nvc_nvm_access_properties

bind nvc_nvm_access nvc_nvm_access_properties i_props (.ref_clk, .rst, .s_axil_araddr,
  .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
  .s_axil_rready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .memReq, .memAck);

// file: bench/nvc_nvm_access_bench.sv
// Purpose: Register-level tests of the NVM access block over AXI4-Lite.
// Assumes: Array model answers after a programmable delay.
// Notes: Start bits are polled until hardware clears them.
`timescale 1ns/1ns
module nvc_nvm_access_bench
  import nvc_pkg::*;
;
  localparam logic [13:0] CfgSeed = 14'h1A00;
  logic ref_clk, rst, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid;
  logic s_axil_rready, s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
  logic s_axil_rvalid, memAck;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb, ackDelay;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [13:0] memRdData, expW;
  nvc_mem_req_t memReq;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] fullExp [4] = '{32'h0000_00FF, 32'h0000_003F, 32'h0000_00FF, 32'h0000_00FF};

  nvc_nvm_access i_nvc_nvm_access (.ref_clk, .rst, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .memReq, .memAck, .memRdData);
  nvc_mem_model #(.CfgSeed(CfgSeed)) i_nvc_mem_model (.ref_clk, .rst, .memReq, .ackDelay,
    .memAck, .memRdData);

  // Free-running bus clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Address and data go out together; each drops once taken.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got = 0;
    @(posedge ref_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid) begin
        check(32'(s_axil_bresp), 32'(er));
        s_axil_bready <= 1'b0;
        got = 1;
      end
    end
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got = 0;
    @(posedge ref_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid) begin
        d = s_axil_rdata;
        r = s_axil_rresp;
        s_axil_rready <= 1'b0;
        got = 1;
      end
    end
  endtask : axiRead

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check(d, exp);
    check(32'(r), 32'(NVC_RESP_OKAY));
  endtask : rdChk

  task automatic setWord(input logic [7:0] hi, input logic [7:0] lo, input logic [13:0] w);
    axiWrite(NVC_OFF_ADDR_HI, 32'(hi), NVC_RESP_OKAY);
    axiWrite(NVC_OFF_ADDR_LO, 32'(lo), NVC_RESP_OKAY);
    axiWrite(NVC_OFF_DATA_LO, 32'(w[7:0]), NVC_RESP_OKAY);
    axiWrite(NVC_OFF_DATA_HI, 32'(w[13:8]), NVC_RESP_OKAY);
  endtask : setWord

  // Starts an access and polls until both start bits are cleared by hardware.
  task automatic run(input logic [31:0] ctrl);
    logic [31:0] d;
    logic [1:0] r;
    int n = 0;
    axiWrite(NVC_OFF_CTRL, ctrl, NVC_RESP_OKAY);
    do axiRead(NVC_OFF_CTRL, d, r);
    while (d[1:0] !== 2'b00 && ++n < 50);
    // A start bit still set after the poll limit counts as a failure.
    check(32'(d[1:0]), 32'h0000_0000);
  endtask : run

  // Hang guard sized well above the whole sequence.
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 5'h00;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 48'h0000_0000_0000;
    s_axil_wstrb = 4'hF;
    ackDelay = 4'h0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdChk(NVC_OFF_ADDR_LO, 32'h0000_0000);
    rdChk(NVC_OFF_ADDR_HI, 32'h0000_0080);
    // All ones written: unimplemented bits must keep their fixed level.
    for (int i = 0; i < 4; i++) begin
      axiWrite(NVC_OFF_DATA_LO + 8'(4 * i), 32'hFFFF_FFFF, NVC_RESP_OKAY);
      rdChk(NVC_OFF_DATA_LO + 8'(4 * i), fullExp[i]);
    end
    axiWrite(8'h14, 32'h0000_0055, NVC_RESP_SLVERR);
    axiRead(8'h14, d, r);
    check(d, 32'h0000_0000);
    check(32'(r), 32'(NVC_RESP_SLVERR));
    // Program word written, data cleared, then read back through a slow array.
    ackDelay <= 4'h6;
    setWord(8'h01, 8'h23, 14'h2A5C);
    run(32'h0000_0086);
    axiWrite(NVC_OFF_DATA_LO, 32'h0000_0000, NVC_RESP_OKAY);
    axiWrite(NVC_OFF_DATA_HI, 32'h0000_0000, NVC_RESP_OKAY);
    run(32'h0000_0081);
    rdChk(NVC_OFF_DATA_LO, 32'h0000_005C);
    rdChk(NVC_OFF_DATA_HI, 32'h0000_002A);
    rdChk(NVC_OFF_ADDR_LO, 32'h0000_0023);
    // Configuration space: try writing words 0 to 9, then read each back.
    ackDelay <= 4'h0;
    for (int i = 0; i < 10; i++) begin
      setWord(8'h00, 8'(i), 14'h0150 + 14'(i));
      run(32'h0000_0046);
    end
    for (int i = 0; i < 10; i++) begin
      setWord(8'h00, 8'(i), 14'h3FFF);
      run(32'h0000_0041);
      expW = (i < 4) ? 14'h0150 + 14'(i) : (i > 5 && i < 9) ? CfgSeed + 14'(i) : 14'h0000;
      rdChk(NVC_OFF_DATA_LO, 32'(expW[7:0]));
      rdChk(NVC_OFF_DATA_HI, 32'(expW[13:8]));
    end
    test_done();
  end
endmodule : nvc_nvm_access_bench
